// *** shared/smst_pkg.sv ***
// constants and types of the synchronous master serial transmitter
`default_nettype none
package smst_pkg;
    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [11:0] IDX_BAUD_CONTROL = 12'h0f7e;
    localparam logic [11:0] IDX_BAUD_HIGH = 12'h0f7f;
    localparam logic [11:0] IDX_TX_STATUS = 12'h0f80;
    localparam logic [11:0] IDX_RX_STATUS = 12'h0f81;
    localparam logic [11:0] IDX_TX_HOLD = 12'h0f82;
    localparam logic [11:0] IDX_BAUD_LOW = 12'h0f83;
    localparam logic [11:0] IDX_FLAG = 12'h0f84;
    localparam logic [11:0] IDX_ENABLE = 12'h0f85;
    localparam logic [11:0] IDX_IRQ_CTRL = 12'h0f86;
    // ==========================================================
    // field positions
    localparam int TXS_CLK_SRC = 7;
    localparam int TXS_NINTH_EN = 6;
    localparam int TXS_TX_EN = 5;
    localparam int TXS_CLOCKED = 4;
    localparam int TXS_SHIFT_EMPTY = 1;
    localparam int TXS_NINTH_VAL = 0;
    localparam int RXS_PORT_EN = 7;
    localparam int RXS_SINGLE_RX = 5;
    localparam int RXS_CONT_RX = 4;
    localparam int BC_IDLE_LEVEL = 4;
    localparam int BC_WIDE_DIV = 3;
    localparam int FLG_TX_EMPTY = 4;
    localparam int FLG_WORD_DONE = 1;
    localparam int IC_GLOBAL = 7;
    localparam int IC_PERIPH = 6;
    // ==========================================================
    // reset values and widths
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] TXS_WRITE_MASK = 8'hfd;
    localparam logic [7:0] FLG_W1C_MASK = 8'h02;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam int BAUD_W = 16;
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;
    // ==========================================================
    // shifter states
    typedef enum logic [1:0] {
        SMST_IDLE,
        SMST_ACTIVE,
        SMST_IDLE_PHASE
    } smst_state_t;
endpackage : smst_pkg
`default_nettype wire

// *** shared/smst_baud_if.sv ***
// link between the transmitter and its bit-rate generator
`timescale 1ns/10ps
`default_nettype none
interface smst_baud_if;
    logic run;
    logic wide;
    logic [smst_pkg::BAUD_W-1:0] divisor;
    logic tick;
    modport ctl (output run, output wide, output divisor, input tick);
    modport gen (input run, input wide, input divisor, output tick);
endinterface : smst_baud_if
`default_nettype wire

// *** logic/smst_baud.sv ***
// bit-rate generator: one tick per half period of the shift clock
`timescale 1ns/10ps
`default_nettype none
module smst_baud (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // transmitter side
    smst_baud_if.gen bif
);
    typedef struct packed {
        logic [smst_pkg::BAUD_W-1:0] cnt;
    } smst_baud_st_t;

    smst_baud_st_t r;
    smst_baud_st_t next_r;
    logic [smst_pkg::BAUD_W-1:0] limit;

    // narrow divisor uses the low byte only
    assign limit = bif.wide ? bif.divisor
        : {{(smst_pkg::BAUD_W-8){1'b0}}, bif.divisor[7:0]};
    assign bif.tick = bif.run && (r.cnt == limit);

    always_comb begin
        next_r = r;
        if (!bif.run || bif.tick) begin
            next_r.cnt = '0;
        end else begin
            next_r.cnt = smst_pkg::BAUD_W'(r.cnt + 1'b1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
endmodule : smst_baud
`default_nettype wire

// *** logic/smst_top.sv ***
// synchronous master serial transmitter with apb registers
// Function
// - master clock when clock source bit set
// - half duplex: transmit and receive exclude each other
// - clocked mode bit selects synchronous operation
// - port enable turns pins into clock/data
// - device drives shift clock on timing line
// - idle level bit sets timing line idle
// - shifter reloads only after last bit leaves
// - reload takes one cycle, then empty flag
// - empty flag not software clearable, write clears
// - irq enable bit gates empty flag interrupt
// - shifter empty status readable, never interrupts
// - shift register has no address
// - ninth bit sent with word when enabled
// - holding buffer write starts transmission
`timescale 1ns/10ps
`default_nettype none
module smst_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins
    output logic serial_timing_line_out,
    output logic serial_timing_line_oe,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    // receive path permission and interrupt
    output logic rx_permit,
    output logic irq
);
    typedef struct packed {
        smst_pkg::smst_state_t state;
        logic [7:0] tx_status_control_reg;
        logic [7:0] rx_status_control_reg;
        logic [7:0] baud_control_reg;
        logic [7:0] baud_divisor_low;
        logic [7:0] baud_divisor_high;
        logic [7:0] tx_holding_buffer;
        logic hold_full;
        logic [8:0] tx_shift_reg;
        logic [3:0] bit_count;
        logic word_done;
        logic [7:0] peripheral_enable_reg;
        logic [7:0] irq_control_reg;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic timing_out;
        logic timing_oe;
        logic data_out;
        logic data_oe;
        logic rx_permit;
        logic irq;
    } smst_top_st_t;

    smst_top_st_t r;
    smst_top_st_t next_r;
    smst_baud_if bif ();

    logic access;
    logic wr;
    logic mapped;
    logic [11:0] idx;
    logic [7:0] rd_byte;
    logic [7:0] flags;
    logic enabled;
    logic rx_req;
    logic can_start;
    logic last_bit;
    logic load;
    logic hold_wr;
    logic idle_level;

    // ==========================================================
    // bit-rate generator
    smst_baud u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .bif(bif)
    );
    assign bif.run = (r.state != smst_pkg::SMST_IDLE);
    assign bif.wide = r.baud_control_reg[smst_pkg::BC_WIDE_DIV];
    assign bif.divisor = {r.baud_divisor_high, r.baud_divisor_low};

    // ==========================================================
    // decode and control terms
    assign access = psel && penable && r.pready;
    assign idx = paddr[13:2];
    assign wr = access && pwrite && mapped;
    assign hold_wr = wr && (idx == smst_pkg::IDX_TX_HOLD);
    assign idle_level = r.baud_control_reg[smst_pkg::BC_IDLE_LEVEL];
    assign enabled = r.rx_status_control_reg[smst_pkg::RXS_PORT_EN]
        && r.tx_status_control_reg[smst_pkg::TXS_CLOCKED]
        && r.tx_status_control_reg[smst_pkg::TXS_CLK_SRC]
        && r.tx_status_control_reg[smst_pkg::TXS_TX_EN];
    assign rx_req = r.rx_status_control_reg[smst_pkg::RXS_SINGLE_RX]
        || r.rx_status_control_reg[smst_pkg::RXS_CONT_RX];
    assign can_start = enabled && !rx_req;
    assign last_bit = r.bit_count ==
        (r.tx_status_control_reg[smst_pkg::TXS_NINTH_EN]
        ? smst_pkg::LAST_BIT_9 : smst_pkg::LAST_BIT_8);
    assign load = r.hold_full && can_start
        && (r.state == smst_pkg::SMST_IDLE
        || (r.state == smst_pkg::SMST_IDLE_PHASE && bif.tick
        && last_bit));

    always_comb begin
        flags = smst_pkg::REG_RESET;
        flags[smst_pkg::FLG_TX_EMPTY] = !r.hold_full;
        flags[smst_pkg::FLG_WORD_DONE] = r.word_done;
    end

    // ==========================================================
    // register read mux
    always_comb begin
        rd_byte = smst_pkg::REG_RESET;
        mapped = (paddr[15:14] == 2'h0) && (paddr[1:0] == 2'h0);
        case (idx)
            smst_pkg::IDX_TX_STATUS: begin
                rd_byte = r.tx_status_control_reg;
                rd_byte[smst_pkg::TXS_SHIFT_EMPTY] =
                    (r.state == smst_pkg::SMST_IDLE);
            end
            smst_pkg::IDX_RX_STATUS: rd_byte = r.rx_status_control_reg;
            smst_pkg::IDX_BAUD_CONTROL: rd_byte = r.baud_control_reg;
            smst_pkg::IDX_BAUD_LOW: rd_byte = r.baud_divisor_low;
            smst_pkg::IDX_BAUD_HIGH: rd_byte = r.baud_divisor_high;
            smst_pkg::IDX_TX_HOLD: rd_byte = r.tx_holding_buffer;
            smst_pkg::IDX_FLAG: rd_byte = flags;
            smst_pkg::IDX_ENABLE: rd_byte = r.peripheral_enable_reg;
            smst_pkg::IDX_IRQ_CTRL: rd_byte = r.irq_control_reg;
            default: mapped = 1'b0;
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        next_r = r;
        // apb answer after one wait cycle
        next_r.pready = psel && penable && !r.pready;
        next_r.pslverr = psel && penable && !r.pready && !mapped;
        if (psel && penable && !r.pready) begin
            next_r.prdata = {24'h00_0000, rd_byte};
        end
        // register writes
        if (wr) begin
            case (idx)
                smst_pkg::IDX_TX_STATUS: begin
                    next_r.tx_status_control_reg =
                        pwdata[7:0] & smst_pkg::TXS_WRITE_MASK;
                end
                smst_pkg::IDX_RX_STATUS: begin
                    next_r.rx_status_control_reg = pwdata[7:0];
                end
                smst_pkg::IDX_BAUD_CONTROL: begin
                    next_r.baud_control_reg = pwdata[7:0];
                end
                smst_pkg::IDX_BAUD_LOW: next_r.baud_divisor_low = pwdata[7:0];
                smst_pkg::IDX_BAUD_HIGH: begin
                    next_r.baud_divisor_high = pwdata[7:0];
                end
                smst_pkg::IDX_FLAG: begin
                    if ((pwdata[7:0] & smst_pkg::FLG_W1C_MASK) != 8'h00) begin
                        next_r.word_done = 1'b0;
                    end
                end
                smst_pkg::IDX_ENABLE: begin
                    next_r.peripheral_enable_reg = pwdata[7:0];
                end
                smst_pkg::IDX_IRQ_CTRL: next_r.irq_control_reg = pwdata[7:0];
                default: next_r.word_done = r.word_done;
            endcase
        end
        // shifter sequence
        unique case (r.state)
            smst_pkg::SMST_IDLE: begin
                next_r.state = smst_pkg::SMST_IDLE;
            end
            smst_pkg::SMST_ACTIVE: begin
                if (!enabled) begin
                    next_r.state = smst_pkg::SMST_IDLE;
                end else if (bif.tick) begin
                    next_r.state = smst_pkg::SMST_IDLE_PHASE;
                end
            end
            smst_pkg::SMST_IDLE_PHASE: begin
                if (!enabled) begin
                    next_r.state = smst_pkg::SMST_IDLE;
                end else if (bif.tick && last_bit) begin
                    next_r.word_done = 1'b1;
                    next_r.state = smst_pkg::SMST_IDLE;
                end else if (bif.tick) begin
                    next_r.tx_shift_reg = {1'b0, r.tx_shift_reg[8:1]};
                    next_r.bit_count = 4'(r.bit_count + 4'h1);
                    next_r.state = smst_pkg::SMST_ACTIVE;
                end
            end
        endcase
        // single-cycle move from holding buffer to shifter
        if (load) begin
            next_r.tx_shift_reg = {
                r.tx_status_control_reg[smst_pkg::TXS_NINTH_VAL],
                r.tx_holding_buffer};
            next_r.bit_count = 4'h0;
            next_r.hold_full = 1'b0;
            next_r.state = smst_pkg::SMST_ACTIVE;
        end
        if (hold_wr) begin
            next_r.tx_holding_buffer = pwdata[7:0];
            next_r.hold_full = 1'b1;
        end
        // pins
        next_r.timing_out = (next_r.state == smst_pkg::SMST_ACTIVE)
            ? !idle_level : idle_level;
        next_r.timing_oe = r.rx_status_control_reg[smst_pkg::RXS_PORT_EN]
            && r.tx_status_control_reg[smst_pkg::TXS_CLOCKED]
            && r.tx_status_control_reg[smst_pkg::TXS_CLK_SRC];
        next_r.data_out = next_r.tx_shift_reg[0];
        next_r.data_oe = enabled;
        next_r.rx_permit = rx_req
            && r.rx_status_control_reg[smst_pkg::RXS_PORT_EN]
            && (next_r.state == smst_pkg::SMST_IDLE);
        // interrupt, shifter status has no source here
        next_r.irq = r.irq_control_reg[smst_pkg::IC_GLOBAL]
            && r.irq_control_reg[smst_pkg::IC_PERIPH]
            && ((flags & r.peripheral_enable_reg) != 8'h00);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign serial_timing_line_out = r.timing_out;
    assign serial_timing_line_oe = r.timing_oe;
    assign serial_data_line_out = r.data_out;
    assign serial_data_line_oe = r.data_oe;
    assign rx_permit = r.rx_permit;
    assign irq = r.irq;

    // ==========================================================
    // checks
    a_master_clock_drive:
    assert property (@(posedge pclk) disable iff (!presetn)
        !r.tx_status_control_reg[smst_pkg::TXS_CLK_SRC]
        |=> !serial_timing_line_oe)
    else $error("timing line driven without clock source bit");

    a_half_duplex_rx:
    assert property (@(posedge pclk) disable iff (!presetn)
        (r.state != smst_pkg::SMST_IDLE) |-> !rx_permit)
    else $error("reception permitted during transmission");

    a_clocked_mode_off:
    assert property (@(posedge pclk) disable iff (!presetn)
        !r.tx_status_control_reg[smst_pkg::TXS_CLOCKED]
        |=> r.state == smst_pkg::SMST_IDLE)
    else $error("shifter runs outside clocked mode");

    a_pins_released:
    assert property (@(posedge pclk) disable iff (!presetn)
        !r.rx_status_control_reg[smst_pkg::RXS_PORT_EN]
        |=> !serial_data_line_oe && !serial_timing_line_oe)
    else $error("pins driven while port disabled");

    a_idle_clock_level:
    assert property (@(posedge pclk) disable iff (!presetn)
        r.state == smst_pkg::SMST_IDLE && $past(r.state) ==
        smst_pkg::SMST_IDLE |-> serial_timing_line_out ==
        $past(r.baud_control_reg[smst_pkg::BC_IDLE_LEVEL]))
    else $error("timing line not at idle level");

    a_reload_after_last:
    assert property (@(posedge pclk) disable iff (!presetn)
        r.state == smst_pkg::SMST_ACTIVE && bif.tick
        |=> r.state != smst_pkg::SMST_ACTIVE)
    else $error("shifter reloaded in mid word");

    a_load_sets_empty:
    assert property (@(posedge pclk) disable iff (!presetn)
        load && !hold_wr |=> !r.hold_full
        && r.state == smst_pkg::SMST_ACTIVE)
    else $error("holding buffer not emptied in one cycle");

    a_empty_flag_sticks:
    assert property (@(posedge pclk) disable iff (!presetn)
        !r.hold_full && !hold_wr |=> !r.hold_full)
    else $error("empty flag cleared without buffer write");

    a_irq_gating:
    assert property (@(posedge pclk) disable iff (!presetn)
        !r.hold_full && r.peripheral_enable_reg[smst_pkg::FLG_TX_EMPTY]
        && r.irq_control_reg[smst_pkg::IC_GLOBAL]
        && r.irq_control_reg[smst_pkg::IC_PERIPH] |=> irq)
    else $error("enabled empty flag gave no interrupt");

    a_bit_count_range:
    assert property (@(posedge pclk) disable iff (!presetn)
        r.bit_count <= smst_pkg::LAST_BIT_9)
    else $error("bit counter past ninth bit");

    a_write_starts_tx:
    assert property (@(posedge pclk) disable iff (!presetn)
        r.state == smst_pkg::SMST_IDLE && r.hold_full && can_start
        |=> r.state == smst_pkg::SMST_ACTIVE ##1
        r.state != smst_pkg::SMST_IDLE)
    else $error("pending word did not start");
endmodule : smst_top
`default_nettype wire

// *** logic/smst_placeholder_none.sv ***
// intentionally empty compile unit
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// *** dv/smst_slave_model.sv ***
// clocked serial slave that collects words from the transmitter pins
`timescale 1ns/10ps
`default_nettype none
module smst_slave_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // serial pins
    input wire logic t_out,
    input wire logic t_oe,
    input wire logic d_out,
    input wire logic d_oe,
    // frame format
    input wire logic idle_hi,
    input wire logic nine,
    // received word
    output logic got,
    output logic [8:0] word
);
    // ==========================================================
    // released lines show the inverse of their last level
    logic pt;
    logic pd;
    logic poe;
    logic [8:0] sh;
    int cnt;
    wire logic t_line = t_oe ? t_out : ~pt;
    wire logic d_line = d_oe ? d_out : ~pd;
    // ==========================================================
    // sample data as the clock returns to idle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pt <= 1'b0;
            pd <= 1'b0;
            poe <= 1'b0;
            got <= 1'b0;
            word <= 9'h000;
            sh = 9'h000;
            cnt = 0;
        end else begin
            got <= 1'b0;
            pt <= t_oe ? t_out : pt;
            pd <= d_oe ? d_out : pd;
            poe <= t_oe;
            if (poe && t_oe && pt !== idle_hi && t_line === idle_hi) begin
                sh = {d_line, sh[8:1]};
                cnt++;
                if (cnt == (nine ? 9 : 8)) begin
                    word <= nine ? sh : {1'b0, sh[8:1]};
                    got <= 1'b1;
                    cnt = 0;
                end
            end
        end
    end
endmodule : smst_slave_model
`default_nettype wire

// *** dv/smst_tb_top.sv ***
// testbench of the synchronous master serial transmitter
`timescale 1ns/10ps
`default_nettype none
module smst_tb_top;
    // ==========================================================
    // register byte addresses
    localparam logic [15:0] A_BC = {2'b00, smst_pkg::IDX_BAUD_CONTROL, 2'b00};
    localparam logic [15:0] A_BH = {2'b00, smst_pkg::IDX_BAUD_HIGH, 2'b00};
    localparam logic [15:0] A_TS = {2'b00, smst_pkg::IDX_TX_STATUS, 2'b00};
    localparam logic [15:0] A_RS = {2'b00, smst_pkg::IDX_RX_STATUS, 2'b00};
    localparam logic [15:0] A_TH = {2'b00, smst_pkg::IDX_TX_HOLD, 2'b00};
    localparam logic [15:0] A_BL = {2'b00, smst_pkg::IDX_BAUD_LOW, 2'b00};
    localparam logic [15:0] A_FL = {2'b00, smst_pkg::IDX_FLAG, 2'b00};
    localparam logic [15:0] A_EN = {2'b00, smst_pkg::IDX_ENABLE, 2'b00};
    localparam logic [15:0] A_IC = {2'b00, smst_pkg::IDX_IRQ_CTRL, 2'b00};
    localparam logic [15:0] A_NONE = 16'h3e1c;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, t_out, t_oe, d_out, d_oe, rx_permit, irq, got;
    logic idle_hi = 1'b0;
    logic nine = 1'b0;
    logic [8:0] word;
    logic [8:0] rxq[$];
    int rxt[$];
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t1, t2, n;
    logic [31:0] r;
    logic e;
    logic [7:0] m[3] = '{8'h80, 8'h10, 8'h20};
    always #10 pclk = ~pclk;
    smst_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_timing_line_out(t_out),
        .serial_timing_line_oe(t_oe), .serial_data_line_out(d_out),
        .serial_data_line_oe(d_oe), .rx_permit(rx_permit), .irq(irq)
    );
    smst_slave_model model (
        .pclk(pclk), .presetn(presetn), .t_out(t_out), .t_oe(t_oe),
        .d_out(d_out), .d_oe(d_oe), .idle_hi(idle_hi), .nine(nine),
        .got(got), .word(word)
    );
    // ==========================================================
    // checking and closing
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task chk(input bit ok);
        cmp_count++;
        if (!ok) begin
            n_mismatch++;
            $display("unexpected at %0t: compare failed", $time);
        end
    endtask : chk
    task cmp_reg(input logic [7:0] g, input logic [7:0] x);
        chk(g === x);
    endtask : cmp_reg
    task cmp_word(input logic [8:0] g, input logic [8:0] x);
        chk(g === x);
    endtask : cmp_word
    task cmp_bit(input logic g, input logic x);
        chk(g === x);
    endtask : cmp_bit
    always @(posedge pclk) begin
        cyc++;
        if (got === 1'b1) begin
            rxq.push_back(word);
            rxt.push_back(cyc);
        end
        if (cyc == 30000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // ==========================================================
    // apb master and serial helpers
    task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1);
        chk(k == 2);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rd(input logic [15:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        cmp_reg(r[7:0], x);
    endtask : rd
    task settle;
        repeat (8) @(negedge pclk);
    endtask : settle
    task exp_word(input logic [8:0] x, output int t);
        while (rxq.size() == 0) begin
            @(posedge pclk);
        end
        cmp_word(rxq.pop_front(), x);
        t = rxt.pop_front();
    endtask : exp_word
    task half_len(output int c);
        c = 0;
        while (t_out === idle_hi) begin
            @(negedge pclk);
        end
        while (t_out !== idle_hi) begin
            @(negedge pclk);
            c++;
        end
    endtask : half_len
    // ==========================================================
    // test sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_FL, 8'h10);
        rd(A_TS, 8'h02);
        rd(A_BC, 8'h00);
        rd(A_EN, 8'h00);
        apb(1'b0, A_NONE, 8'h00);
        cmp_bit(e, 1'b1);
        cmp_bit(t_oe, 1'b0);
        cmp_bit(d_oe, 1'b0);
        wr(A_BL, 8'h03);
        wr(A_BH, 8'h01);
        wr(A_RS, 8'h80);
        for (int i = 0; i < 3; i++) begin
            wr(A_TS, 8'hb0 & ~m[i]);
            wr(A_TH, 8'h22);
            repeat (100) @(posedge pclk);
            cmp_bit(rxq.size() == 0, 1'b1);
            rd(A_TS, (8'hb0 & ~m[i]) | 8'h02);
        end
        rd(A_FL, 8'h00);
        wr(A_TS, 8'hb0);
        half_len(n);
        cmp_reg(n[7:0], 8'h04);
        exp_word(9'h022, t1);
        settle;
        cmp_bit(t_oe, 1'b1);
        cmp_bit(d_oe, 1'b1);
        cmp_bit(t_out, 1'b0);
        rd(A_TS, 8'hb2);
        rd(A_FL, 8'h12);
        wr(A_FL, 8'h12);
        rd(A_FL, 8'h10);
        wr(A_TH, 8'h3c);
        wr(A_TH, 8'hc3);
        rd(A_FL, 8'h00);
        rd(A_TS, 8'hb0);
        exp_word(9'h03c, t1);
        exp_word(9'h0c3, t2);
        cmp_bit(t2 - t1 >= 64 && t2 - t1 <= 66, 1'b1);
        wr(A_FL, 8'h02);
        wr(A_RS, 8'h00);
        wr(A_BH, 8'h00);
        wr(A_BL, 8'h01);
        wr(A_BC, 8'h18);
        idle_hi <= 1'b1;
        nine <= 1'b1;
        wr(A_RS, 8'h80);
        settle;
        cmp_bit(t_out, 1'b1);
        wr(A_TS, 8'hf1);
        wr(A_TH, 8'h5a);
        half_len(n);
        cmp_reg(n[7:0], 8'h02);
        exp_word(9'h15a, t1);
        nine <= 1'b0;
        wr(A_TS, 8'hb0);
        wr(A_TH, 8'h77);
        wr(A_RS, 8'h90);
        settle;
        cmp_bit(rx_permit, 1'b0);
        exp_word(9'h077, t1);
        settle;
        cmp_bit(rx_permit, 1'b1);
        wr(A_TH, 8'h66);
        repeat (100) @(posedge pclk);
        cmp_bit(rxq.size() == 0, 1'b1);
        rd(A_TS, 8'hb2);
        wr(A_RS, 8'h80);
        exp_word(9'h066, t1);
        wr(A_FL, 8'h02);
        wr(A_EN, 8'h10);
        wr(A_IC, 8'h40);
        settle;
        cmp_bit(irq, 1'b0);
        wr(A_IC, 8'hc0);
        settle;
        cmp_bit(irq, 1'b1);
        wr(A_EN, 8'h02);
        settle;
        cmp_bit(irq, 1'b0);
        wr(A_TH, 8'h99);
        exp_word(9'h099, t1);
        settle;
        cmp_bit(irq, 1'b1);
        wr(A_FL, 8'h02);
        settle;
        cmp_bit(irq, 1'b0);
        tally_and_finish();
    end
endmodule : smst_tb_top
`default_nettype wire
